// ===== common/cbie_gate_if.sv
// Interface carrying flags and enables to the gating module and gated requests back from it.
`timescale 1ns/100ps
interface cbie_gate_if;
    import cbie_pkg::*;
    logic [NBUF-1:0] flags;
    logic [NBUF-1:0] local_en;
    logic [NBUF-1:0] is_tx;
    logic grp_tx;
    logic grp_rx;
    logic enabled;
    logic [NBUF-1:0] pending;
    modport ctrl (output flags, local_en, is_tx, grp_tx, grp_rx, enabled,
        input pending);
    modport gate (input flags, local_en, is_tx, grp_tx, grp_rx, enabled,
        output pending);
endinterface

// ===== common/cbie_pkg.sv
// Register map, field layout and mode codes of the buffer irq enable block.
// Operation
// [RULE1] Transmit enables for buffers 2 to 0 sit in bits 4 down to 2.
// [RULE2] Transmit enable bits 7 to 5 and 1 to 0 are absent and read zero.
// [RULE3] Both enable registers work only in enhanced modes 1 and 2.
// [RULE4] A transmit buffer interrupts only with local and group enable set.
// [RULE5] Programmable buffer enables 5 to 0 sit in bits 7 down to 2.
// [RULE6] Buffer enable bits 1 and 0 enable receive buffers 1 and 0.
// [RULE7] Buffer enable interrupts also need the matching group enable.
// [RULE8] The request ORs, over all buffers, flag and local and group enable.
package cbie_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_TX_EN = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_BUF_EN = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_GROUP = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_MODE = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_CLEAR = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_EN = 4'h6;
    localparam logic [ADDR_W-1:0] ADDR_PEND = 4'h7;
    localparam int TX_LSB = 2;
    localparam int TX_N = 3;
    localparam int RX_N = 2;
    localparam int PB_N = 6;
    localparam int PB_LSB = 2;
    localparam int NBUF = TX_N + RX_N + PB_N;
    localparam int GRP_TX_BIT = 0;
    localparam int GRP_RX_BIT = 1;
    localparam int MODE_W = 2;
    localparam logic [DATA_W-1:0] TX_EN_MASK = 8'h1C;
    localparam logic [DATA_W-1:0] GRP_MASK = 8'h03;
    localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
    localparam int EV_W = 2;
    localparam int EV_RISE = 0;
    localparam int EV_DROP = 1;
    typedef enum logic [MODE_W-1:0] {
        CBIE_MODE_LEGACY,
        CBIE_MODE_ENH1,
        CBIE_MODE_ENH2,
        CBIE_MODE_RSVD
    } cbie_mode_type;
endpackage

// ===== design/cbie_gate.sv
// Per-buffer gating of interrupt flags by local and group enables.
`timescale 1ns/100ps
module cbie_gate (
    cbie_gate_if.gate g
);
    import cbie_pkg::*;
    // Each buffer is gated by its own enable and its transmit or receive group.
    for (genvar b = 0; b < NBUF; b++) begin : g_buf
        // [RULE4] [RULE7] local and group.
        assign g.pending[b] = g.enabled && g.flags[b] && g.local_en[b] &&
            (g.is_tx[b] ? g.grp_tx : g.grp_rx);
    end
endmodule

// ===== design/cbie_top.sv
// Buffer interrupt enable registers, gating and event status for a CAN block.
`timescale 1ns/100ps
module cbie_top (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic [cbie_pkg::ADDR_W-1:0] i_addr,
    input wire logic [cbie_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [cbie_pkg::NBUF-1:0] i_buf_flags,
    input wire logic [cbie_pkg::NBUF-1:0] i_pb_is_tx,
    output logic [cbie_pkg::DATA_W-1:0] o_rdata,
    output logic o_buf_irq,
    output logic o_irq
);
    import cbie_pkg::*;

    logic [TX_N-1:0] dedicated_tx_irq_en;
    logic [PB_N-1:0] programmable_buf_irq_en;
    logic [RX_N-1:0] dedicated_rx_irq_en;
    logic group_tx_irq_en;
    logic group_rx_irq_en;
    cbie_mode_type mode;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] irq_en;
    logic req_q;
    logic enh_mode;
    logic [DATA_W-1:0] next_rdata;
    logic next_req;
    logic [EV_W-1:0] event_set;

    cbie_gate_if gif ();

    // [RULE3] enhanced modes only.
    assign enh_mode = (mode == CBIE_MODE_ENH1) || (mode == CBIE_MODE_ENH2);

    // Buffer order: tx0..tx2, rx0..rx1, programmable 0..5.
    assign gif.flags = i_buf_flags;
    assign gif.local_en = {programmable_buf_irq_en, dedicated_rx_irq_en,
        dedicated_tx_irq_en};
    assign gif.is_tx = {i_pb_is_tx[NBUF-1:TX_N+RX_N],
        {RX_N{1'b0}}, {TX_N{1'b1}}};
    assign gif.grp_tx = group_tx_irq_en;
    assign gif.grp_rx = group_rx_irq_en;
    assign gif.enabled = enh_mode;

    cbie_gate u_gate (
        .g(gif.gate)
    );

    // [RULE8] OR of gated buffers.
    assign next_req = |gif.pending;

    // Transmit enables; writes are dropped in legacy mode. The stored value
    // is kept on a switch back to legacy, so a return to an enhanced mode
    // brings the old enables back without software having to rewrite them.
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            dedicated_tx_irq_en <= '0;
        end else if (i_wr && i_addr == ADDR_TX_EN && enh_mode) begin
            // [RULE1] bits 4 to 2.
            dedicated_tx_irq_en <= i_wdata[TX_LSB +: TX_N];
        end
    end

    // Programmable and receive enables share one register.
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            programmable_buf_irq_en <= '0;
            dedicated_rx_irq_en <= '0;
        end else if (i_wr && i_addr == ADDR_BUF_EN && enh_mode) begin
            // [RULE5] bits 7 to 2.
            programmable_buf_irq_en <= i_wdata[PB_LSB +: PB_N];
            // [RULE6] bits 1 and 0.
            dedicated_rx_irq_en <= i_wdata[RX_N-1:0];
        end
    end

    // Group enables stand apart from the buffer enables and are always
    // writable, so software can arm a group before it picks the mode.
    // [RULE4] [RULE7] group enables.
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            group_tx_irq_en <= 1'b0;
            group_rx_irq_en <= 1'b0;
        end else if (i_wr && i_addr == ADDR_GROUP) begin
            group_tx_irq_en <= i_wdata[GRP_TX_BIT];
            group_rx_irq_en <= i_wdata[GRP_RX_BIT];
        end
    end

    // Mode select; the reserved code counts as not enhanced.
    // [RULE3] mode register.
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mode <= CBIE_MODE_LEGACY;
        end else if (i_wr && i_addr == ADDR_MODE) begin
            mode <= cbie_mode_type'(i_wdata[MODE_W-1:0]);
        end
    end

    // Buffer request output, registered so it comes from a flip-flop.
    // The gate is pure logic, so this register is the only latency.
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            req_q <= 1'b0;
        end else begin
            req_q <= next_req;
        end
    end
    assign o_buf_irq = req_q;

    // Edges of the request form the status events.
    // Both are taken against the registered request, so they match o_buf_irq.
    assign event_set[EV_RISE] = next_req && !req_q;
    assign event_set[EV_DROP] = !next_req && req_q;

    // Sticky status; a set in the clearing cycle wins over the clear.
    // Letting the clear win would lose an edge that lands in the same cycle
    // as the software write, and the interrupt for it would never come.
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            status <= '0;
        end else if (i_wr && i_addr == ADDR_CLEAR) begin
            status <= (status & ~i_wdata[EV_W-1:0]) | event_set;
        end else begin
            status <= status | event_set;
        end
    end

    // Status interrupt enable register.
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            irq_en <= '0;
        end else if (i_wr && i_addr == ADDR_IRQ_EN) begin
            irq_en <= i_wdata[EV_W-1:0];
        end
    end

    // Level interrupt, looked ahead one cycle so it tracks status exactly.
    // Computing it from the registered status would leave the output one
    // cycle behind a clear, and software could see a stale request.
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_irq <= 1'b0;
        end else if (i_wr && i_addr == ADDR_CLEAR) begin
            o_irq <= |(((status & ~i_wdata[EV_W-1:0]) | event_set) & irq_en);
        end else if (i_wr && i_addr == ADDR_IRQ_EN) begin
            o_irq <= |((status | event_set) & i_wdata[EV_W-1:0]);
        end else begin
            o_irq <= |((status | event_set) & irq_en);
        end
    end

    // Read mux; unused and unmapped bits read zero.
    // The clear register is write-only and falls to the default as well,
    // so a read of it never disturbs the status.
    always_comb begin
        next_rdata = RESET_BYTE;
        unique case (i_addr)
            ADDR_TX_EN: begin
                // [RULE2] unused bits zero.
                next_rdata[TX_LSB +: TX_N] = dedicated_tx_irq_en;
            end
            ADDR_BUF_EN: begin
                next_rdata = {programmable_buf_irq_en, dedicated_rx_irq_en};
            end
            ADDR_GROUP: begin
                next_rdata[GRP_TX_BIT] = group_tx_irq_en;
                next_rdata[GRP_RX_BIT] = group_rx_irq_en;
            end
            ADDR_MODE: begin
                next_rdata[MODE_W-1:0] = mode;
            end
            ADDR_STATUS: begin
                next_rdata[EV_W-1:0] = status;
            end
            ADDR_IRQ_EN: begin
                next_rdata[EV_W-1:0] = irq_en;
            end
            ADDR_PEND: begin
                next_rdata[DATA_W-1:0] = gif.pending[DATA_W-1:0];
            end
            default: begin
                next_rdata = RESET_BYTE;
            end
        endcase
    end

    // Read data stands only in the cycle after the read strobe.
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rdata <= RESET_BYTE;
        end else if (i_rd) begin
            o_rdata <= next_rdata;
        end else begin
            o_rdata <= RESET_BYTE;
        end
    end

    // Checks of register layout and gating.
    tx_layout_a: assert property ( // [RULE2]
        @(posedge i_mclk) disable iff (i_sys_rst)
        i_rd && i_addr == ADDR_TX_EN |=> (o_rdata & ~TX_EN_MASK) == RESET_BYTE)
        else $error("Unused transmit enable bits read nonzero.");
    tx_store_a: assert property ( // [RULE1]
        @(posedge i_mclk) disable iff (i_sys_rst)
        i_wr && i_addr == ADDR_TX_EN && enh_mode |=>
        dedicated_tx_irq_en == $past(i_wdata[TX_LSB +: TX_N]))
        else $error("Transmit enable did not store bits 4 to 2.");
    legacy_lock_a: assert property ( // [RULE3]
        @(posedge i_mclk) disable iff (i_sys_rst)
        !enh_mode |=> !req_q)
        else $error("Buffer request raised in legacy mode.");
    buf_store_a: assert property ( // [RULE5]
        @(posedge i_mclk) disable iff (i_sys_rst)
        i_wr && i_addr == ADDR_BUF_EN && enh_mode |=>
        programmable_buf_irq_en == $past(i_wdata[DATA_W-1:PB_LSB]))
        else $error("Programmable enables did not store bits 7 to 2.");
    rx_store_a: assert property ( // [RULE6]
        @(posedge i_mclk) disable iff (i_sys_rst)
        i_wr && i_addr == ADDR_BUF_EN && enh_mode |=>
        dedicated_rx_irq_en == $past(i_wdata[RX_N-1:0]))
        else $error("Receive enables did not store bits 1 and 0.");
    tx_group_a: assert property ( // [RULE4]
        @(posedge i_mclk) disable iff (i_sys_rst)
        !group_tx_irq_en |-> gif.pending[TX_N-1:0] == '0)
        else $error("Transmit buffer interrupt without group enable.");
    rx_group_a: assert property ( // [RULE7]
        @(posedge i_mclk) disable iff (i_sys_rst)
        !group_rx_irq_en |-> gif.pending[TX_N+RX_N-1:TX_N] == '0)
        else $error("Receive buffer interrupt without group enable.");
    req_or_a: assert property ( // [RULE8]
        @(posedge i_mclk) disable iff (i_sys_rst)
        enh_mode && |(i_buf_flags[TX_N-1:0] & dedicated_tx_irq_en) &&
        group_tx_irq_en |=> o_buf_irq)
        else $error("Enabled transmit flag did not raise the request.");

    // Read data, write refusal in legacy mode and read-back of the enables and the pending view.
    rdata_idle_a: assert property ( // [RULE2]
        @(posedge i_mclk) disable iff (i_sys_rst)
        !i_rd |=> o_rdata == RESET_BYTE)
        else $error("Read data did not return to zero after a read.");
    tx_legacy_a: assert property ( // [RULE3]
        @(posedge i_mclk) disable iff (i_sys_rst)
        i_wr && i_addr == ADDR_TX_EN && !enh_mode |=>
        $stable(dedicated_tx_irq_en))
        else $error("Transmit enables changed outside enhanced mode.");
    buf_legacy_a: assert property ( // [RULE3]
        @(posedge i_mclk) disable iff (i_sys_rst)
        i_wr && i_addr == ADDR_BUF_EN && !enh_mode |=>
        $stable({programmable_buf_irq_en, dedicated_rx_irq_en}))
        else $error("Buffer enables changed outside enhanced mode.");
    tx_read_a: assert property ( // [RULE1]
        @(posedge i_mclk) disable iff (i_sys_rst)
        i_rd && i_addr == ADDR_TX_EN |=>
        o_rdata[TX_LSB +: TX_N] == $past(dedicated_tx_irq_en))
        else $error("Transmit enables read back wrong.");
    buf_read_a: assert property ( // [RULE6]
        @(posedge i_mclk) disable iff (i_sys_rst)
        i_rd && i_addr == ADDR_BUF_EN |=>
        o_rdata == $past({programmable_buf_irq_en, dedicated_rx_irq_en}))
        else $error("Buffer enables read back wrong.");
    pend_read_a: assert property ( // [RULE8]
        @(posedge i_mclk) disable iff (i_sys_rst)
        i_rd && i_addr == ADDR_PEND |=>
        o_rdata == $past(gif.pending[DATA_W-1:0]))
        else $error("Pending view read back wrong.");

    // Requests from the receive and programmable buffers and the quiet case.
    rx_req_a: assert property ( // [RULE7]
        @(posedge i_mclk) disable iff (i_sys_rst)
        enh_mode && group_rx_irq_en &&
        |(i_buf_flags[TX_N +: RX_N] & dedicated_rx_irq_en) |=> o_buf_irq)
        else $error("Enabled receive flag did not raise the request.");
    pb_tx_req_a: assert property ( // [RULE7]
        @(posedge i_mclk) disable iff (i_sys_rst)
        enh_mode && group_tx_irq_en &&
        |(i_buf_flags[NBUF-1:TX_N+RX_N] & programmable_buf_irq_en &
        i_pb_is_tx[NBUF-1:TX_N+RX_N]) |=> o_buf_irq)
        else $error("Enabled programmable transmit flag gave no request.");
    pb_rx_req_a: assert property ( // [RULE7]
        @(posedge i_mclk) disable iff (i_sys_rst)
        enh_mode && group_rx_irq_en &&
        |(i_buf_flags[NBUF-1:TX_N+RX_N] & programmable_buf_irq_en &
        ~i_pb_is_tx[NBUF-1:TX_N+RX_N]) |=> o_buf_irq)
        else $error("Enabled programmable receive flag gave no request.");
    req_quiet_a: assert property ( // [RULE8]
        @(posedge i_mclk) disable iff (i_sys_rst)
        (i_buf_flags & {programmable_buf_irq_en, dedicated_rx_irq_en,
        dedicated_tx_irq_en}) == '0 |=> !o_buf_irq)
        else $error("Request raised with no locally enabled flag.");

    // Status events and the level interrupt.
    irq_level_a: assert property ( // [RULE8]
        @(posedge i_mclk) disable iff (i_sys_rst)
        o_irq == |(status & irq_en))
        else $error("Level interrupt does not follow enabled status.");
    set_wins_a: assert property ( // [RULE8]
        @(posedge i_mclk) disable iff (i_sys_rst)
        i_wr && i_addr == ADDR_CLEAR && event_set[EV_RISE] |=>
        status[EV_RISE])
        else $error("Clear in the event cycle lost the status bit.");
endmodule

// ===== verification/can_buffer_irq_enable_tb_top.sv
// Self-checking bench for the buffer interrupt enable block.
`timescale 1ns/100ps
module can_buffer_irq_enable_tb_top;
    import cbie_pkg::*;
    logic i_mclk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [ADDR_W-1:0] i_addr = 4'h0;
    logic [DATA_W-1:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [NBUF-1:0] src_set = 11'h000;
    logic [NBUF-1:0] src_tx = 11'h540;
    logic [NBUF-1:0] flags;
    logic [NBUF-1:0] is_tx;
    logic [NBUF-1:0] lm;
    logic [DATA_W-1:0] o_rdata;
    logic [DATA_W-1:0] rv;
    logic o_buf_irq;
    logic o_irq;
    logic e;
    int err_count = 0;
    int comparisons = 0;
    // Free-running system clock at 100 MHz.
    initial forever #5 i_mclk = ~i_mclk;
    cbie_buf_src src (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_set_flags(src_set), .i_set_tx(src_tx), .o_flags(flags),
        .o_is_tx(is_tx));
    cbie_top dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_buf_flags(flags),
        .i_pb_is_tx(is_tx), .o_rdata(o_rdata), .o_buf_irq(o_buf_irq),
        .o_irq(o_irq));
    task automatic tally_and_finish;
        $display("Counts: %0d mismatches, %0d comparisons", err_count,
            comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic got, input logic exp);
        chk_reg({7'h00, got}, {7'h00, exp});
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe edge.
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    // One edge through the source model, one through the block.
    task automatic settle(input logic [NBUF-1:0] v);
        @(posedge i_mclk);
        src_set <= v;
        repeat (2) @(posedge i_mclk);
        #1;
    endtask
    // A hung run is cut short and counted as a mismatch.
    initial begin
        #500000;
        err_count++;
        tally_and_finish();
    end
    initial begin
        repeat (6) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        for (int a = 0; a < 9; a++) begin
            rd(a[3:0], rv);
            chk_reg(rv, 8'h00);
        end
        // Legacy and reserved modes refuse the enable writes.
        for (int m = 0; m < 4; m += 3) begin
            wr(ADDR_MODE, 8'(m));
            wr(ADDR_TX_EN, 8'hFF);
            wr(ADDR_BUF_EN, 8'hFF);
            rd(ADDR_TX_EN, rv);
            chk_reg(rv, 8'h00);
            rd(ADDR_BUF_EN, rv);
            chk_reg(rv, 8'h00);
        end
        wr(ADDR_MODE, 8'h01);
        wr(ADDR_TX_EN, 8'hE3);
        rd(ADDR_TX_EN, rv);
        chk_reg(rv, 8'h00);
        wr(ADDR_TX_EN, 8'hFF);
        rd(ADDR_TX_EN, rv);
        chk_reg(rv, 8'h1C);
        wr(ADDR_BUF_EN, 8'hA5);
        rd(ADDR_BUF_EN, rv);
        chk_reg(rv, 8'hA5);
        // Each buffer against every group pair, then its own enable off.
        for (int i = 0; i < NBUF; i++) begin
            for (int g = 0; g < 4; g++) begin
                wr(ADDR_GROUP, 8'(g));
                wr(ADDR_TX_EN, 8'h1C);
                wr(ADDR_BUF_EN, 8'hFF);
                settle(11'(1 << i));
                e = (i < 3 || (i > 4 && src_tx[i])) ? g[0] : g[1];
                chk_pin(o_buf_irq, e);
                if (i < 8) begin
                    rd(ADDR_PEND, rv);
                    chk_reg(rv, {7'h00, e} << i);
                end
                lm = ~(11'(1 << i));
                wr(ADDR_TX_EN, {3'h0, lm[2:0], 2'h0});
                wr(ADDR_BUF_EN, {lm[10:5], lm[4:3]});
                settle(11'(1 << i));
                chk_pin(o_buf_irq, 1'b0);
            end
        end
        // Sticky status events, masking and clearing of the level output.
        wr(ADDR_MODE, 8'h02);
        wr(ADDR_GROUP, 8'h03);
        wr(ADDR_IRQ_EN, 8'h03);
        settle(11'h000);
        wr(ADDR_CLEAR, 8'h03);
        settle(11'h7FF);
        chk_pin(o_buf_irq, 1'b1);
        rd(ADDR_STATUS, rv);
        chk_reg(rv, 8'h01);
        chk_pin(o_irq, 1'b1);
        // Read data stand for one cycle only, then fall back to zero.
        @(posedge i_mclk);
        #1;
        chk_reg(o_rdata, 8'h00);
        wr(ADDR_IRQ_EN, 8'h02);
        settle(11'h7FF);
        chk_pin(o_irq, 1'b0);
        settle(11'h000);
        chk_pin(o_irq, 1'b1);
        wr(ADDR_CLEAR, 8'h02);
        settle(11'h000);
        rd(ADDR_STATUS, rv);
        chk_reg(rv, 8'h01);
        chk_pin(o_irq, 1'b0);
        wr(ADDR_MODE, 8'h00);
        settle(11'h7FF);
        chk_pin(o_buf_irq, 1'b0);
        // Transmit enables survive the drop to legacy mode.
        rd(ADDR_TX_EN, rv);
        chk_reg(rv, 8'h1C);
        tally_and_finish();
    end
endmodule

// ===== verification/cbie_buf_src.sv
// Behavioural model of the buffer flag sources beside the block.
`timescale 1ns/100ps
module cbie_buf_src (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic [cbie_pkg::NBUF-1:0] i_set_flags,
    input wire logic [cbie_pkg::NBUF-1:0] i_set_tx,
    output logic [cbie_pkg::NBUF-1:0] o_flags,
    output logic [cbie_pkg::NBUF-1:0] o_is_tx
);
    import cbie_pkg::*;
    // Flags are levels launched on the clock, as a buffer engine would.
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_flags <= '0;
            o_is_tx <= '0;
        end else begin
            o_flags <= i_set_flags;
            o_is_tx <= i_set_tx;
        end
    end
endmodule
